// ### hw/can_rx_status.sv
// can error counters, payload bytes and receive/wake/error interrupt flags behind apb
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "can_rx_cfg.svh"

module can_rx_status (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive fifo foreground buffer
  input wire logic rxFgLoad,
  input wire logic [63:0] rxFgData,
  input wire logic [3:0] rxFgLength,
  input wire logic rxOverrun,
  output logic rxRelease,
  // fault-confinement events from the protocol engine
  input wire logic txErr,
  input wire logic txOk,
  input wire logic rxErr,
  input wire logic rxErrDominant,
  input wire logic rxOk,
  input wire logic busOffRecover,
  // can receive pin, asynchronous
  input wire logic canRx,
  // interrupt
  output logic irq
);
  logic [3:0] ctrl_q;
  logic sleepAck_q, initAck_q, powerDown_q, sleptBeforePd_q;
  logic [7:0] flag_q, flag_d, mask_q;
  logic [8:0] tec_q, tec_d;
  logic [7:0] rec_q, rec_d;
  logic [3:0] len_q;
  logic [7:0] payload_q [`PAY_BYTES];
  logic canRxMeta_q, canRxSync_q, canRxPrev_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q, rxRelease_q;
  can_rx_pkg::bus_state_t txSt_q, rxSt_q;

  function automatic can_rx_pkg::bus_state_t busLevel(input logic [8:0] cnt);
    if (cnt >= `CNT_BUSOFF) begin
      return can_rx_pkg::BUS_OFF;
    end else if (cnt >= `CNT_PASSIVE) begin
      return can_rx_pkg::BUS_PASSIVE;
    end else if (cnt >= `CNT_WARN) begin
      return can_rx_pkg::BUS_WARN;
    end
    return can_rx_pkg::BUS_OK;
  endfunction

  // apb decode
  wire setup = psel & ~penable;
  wire wrAcc = psel & penable & pready_q & pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire isPay = paddr >= `OFF_PAY && paddr <= `OFF_PAY_END && paddr[1:0] == 2'b00;
  wire [2:0] payIdx = paddr[4:2];
  wire isCtrl = paddr == `OFF_CTRL;
  wire isStat = paddr == `OFF_STAT;
  wire isFlag = paddr == `OFF_FLAG;
  wire isMask = paddr == `OFF_MASK;
  wire isTxe = paddr == `OFF_TXERR;
  wire isRxe = paddr == `OFF_RXERR;
  wire isLen = paddr == `OFF_LEN;
  wire mapped = isPay | isCtrl | isStat | isFlag | isMask | isTxe | isRxe | isLen;
  // counters change under the engine's feet outside sleep/init, so reads return zero there
  wire cntValid = (ctrl_q[`CTRL_SLEEP] & sleepAck_q) | (ctrl_q[`CTRL_INIT] & initAck_q);
  wire [7:0] txeRd = cntValid ? tec_q[7:0] : `RST_REG;
  wire [7:0] rxeRd = cntValid ? rec_q : `RST_REG;
  wire [7:0] statRd = {5'h00, powerDown_q, initAck_q, sleepAck_q};
  wire [7:0] flagRd = {flag_q[7:6], txSt_q, rxSt_q, flag_q[1:0]};
  wire [7:0] rdByte = isPay ? payload_q[payIdx] :
                      isCtrl ? {4'h0, ctrl_q} :
                      isStat ? statRd :
                      isFlag ? flagRd :
                      isMask ? mask_q :
                      isTxe ? txeRd :
                      isRxe ? rxeRd :
                      isLen ? {4'h0, len_q} : `RST_REG;

  // fault confinement
  wire txBusOff = tec_q >= `CNT_BUSOFF;
  always_comb begin
    tec_d = tec_q;
    rec_d = rec_q;
    if (busOffRecover) begin
      tec_d = 9'h000;
      rec_d = 8'h00;
    end else begin
      if (txErr && !txBusOff) begin
        tec_d = tec_q + `CNT_TX_STEP;
      end else if (txOk && tec_q != 9'h000 && !txBusOff) begin
        tec_d = tec_q - 9'h001;
      end
      if (rxErrDominant) begin
        rec_d = (rec_q > 8'hF7) ? 8'hFF : rec_q + `CNT_RX_STEP;
      end else if (rxErr && rec_q != 8'hFF) begin
        rec_d = rec_q + 8'h01;
      end else if (rxOk && rec_q != 8'h00) begin
        rec_d = rec_q - 8'h01;
      end
    end
  end

  wire can_rx_pkg::bus_state_t txStNew = busLevel(tec_q);
  wire can_rx_pkg::bus_state_t rxStNew = busLevel({1'b0, rec_q});
  wire stChange = txStNew != txSt_q || rxStNew != rxSt_q;

  // wake-up: dominant edge on the bus while asleep, or while powered down after an acked sleep
  wire busFall = canRxPrev_q & ~canRxSync_q;
  wire asleep = sleepAck_q | (powerDown_q & sleptBeforePd_q);
  wire wakeEv = busFall & asleep & ctrl_q[`CTRL_WAKE_EN] & mask_q[`FLG_WAKE];

  // sticky flags: hardware set wins over a write-one clear
  wire [7:0] setV = {wakeEv, stChange, 4'h0, rxOverrun, rxFgLoad};
  wire [7:0] clrV = (wrAcc && isFlag) ? (wb & `FLG_STICKY) : `RST_REG;
  assign flag_d = (flag_q & ~clrV) | setV;
  wire rxfCleared = clrV[`FLG_RXF] & flag_q[`FLG_RXF] & ~rxFgLoad;

  // the length code above eight still means eight bytes
  wire [3:0] nLoad = rxFgLength > 4'h8 ? 4'h8 : rxFgLength;
  // a frame hand-over wins over a software write to the length register in the same cycle
  wire [3:0] lenNext = rxFgLoad ? rxFgLength : (wrAcc && isLen) ? wb[3:0] : len_q;
  wire [7:0] maskNext = (wrAcc && isMask) ? (wb & `FLG_STICKY) : mask_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      canRxMeta_q <= 1'b1;
      canRxSync_q <= 1'b1;
      canRxPrev_q <= 1'b1;
    end else begin
      canRxMeta_q <= canRx;
      canRxSync_q <= canRxMeta_q;
      canRxPrev_q <= canRxSync_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 4'h0;
      mask_q <= `RST_REG;
      len_q <= 4'h0;
    end else begin
      // counter, status and unmapped addresses take no write
      if (wrAcc && isCtrl) ctrl_q <= wb[3:0];
      mask_q <= maskNext;
      len_q <= lenNext;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleepAck_q <= 1'b0;
      initAck_q <= 1'b0;
      powerDown_q <= 1'b0;
      sleptBeforePd_q <= 1'b0;
    end else begin
      sleepAck_q <= ctrl_q[`CTRL_SLEEP];
      initAck_q <= ctrl_q[`CTRL_INIT];
      powerDown_q <= ctrl_q[`CTRL_PDOWN];
      if (ctrl_q[`CTRL_PDOWN] && !powerDown_q) sleptBeforePd_q <= sleepAck_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tec_q <= 9'h000;
      rec_q <= 8'h00;
      txSt_q <= can_rx_pkg::BUS_OK;
      rxSt_q <= can_rx_pkg::BUS_OK;
      flag_q <= `RST_REG;
    end else begin
      tec_q <= tec_d;
      rec_q <= rec_d;
      txSt_q <= txStNew;
      rxSt_q <= rxStNew;
      flag_q <= flag_d;
    end
  end

  // payload: software writes for transmit, a foreground load overwrites
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `PAY_BYTES; i++) payload_q[i] <= 8'h00;
    end else if (rxFgLoad) begin
      for (int i = 0; i < `PAY_BYTES; i++) begin
        payload_q[i] <= (4'(i) < nLoad) ? rxFgData[8*i +: 8] : 8'h00;
      end
    end else if (wrAcc && isPay) begin
      payload_q[payIdx] <= wb;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      rxRelease_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) prdata_q <= {24'h000000, rdByte};
      // next mask value, so the request never lags a mask write by a cycle
      irq_q <= |(flag_d & maskNext);
      rxRelease_q <= rxfCleared;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign rxRelease = rxRelease_q;

  // checks
  property p_cnt_hidden;
    @(posedge clk) disable iff (!reset_n)
    setup && (isTxe || isRxe) && !cntValid |=> prdata == 32'h0000_0000;
  endproperty
  a_cnt_hidden: assert property (p_cnt_hidden) else $error("counter visible outside sleep/init");

  property p_cnt_nowrite;
    @(posedge clk) disable iff (!reset_n)
    wrAcc && isTxe && !txErr && !txOk && !busOffRecover |=> tec_q == $past(tec_q);
  endproperty
  a_cnt_nowrite: assert property (p_cnt_nowrite) else $error("counter changed by write");

  property p_txe_read;
    @(posedge clk) disable iff (!reset_n)
    setup && isTxe && cntValid |=> prdata[7:0] == $past(tec_q[7:0]);
  endproperty
  a_txe_read: assert property (p_txe_read) else $error("tx count read mismatch");

  property p_pay_wr;
    @(posedge clk) disable iff (!reset_n)
    wrAcc && isPay && !rxFgLoad |=> payload_q[$past(payIdx)] == $past(wb);
  endproperty
  a_pay_wr: assert property (p_pay_wr) else $error("payload byte not stored");

  property p_pay_len;
    @(posedge clk) disable iff (!reset_n)
    rxFgLoad && rxFgLength == 4'h0 |=> payload_q[0] == 8'h00;
  endproperty
  a_pay_len: assert property (p_pay_len) else $error("byte beyond length kept");

  property p_rxf;
    @(posedge clk) disable iff (!reset_n)
    rxFgLoad && maskNext[`FLG_RXF] |=> flag_q[`FLG_RXF] && irq;
  endproperty
  a_rxf: assert property (p_rxf) else $error("receive-full or irq missing");

  property p_rxf_again;
    @(posedge clk) disable iff (!reset_n)
    rxFgLoad && clrV[`FLG_RXF] |=> flag_q[`FLG_RXF] && !rxRelease;
  endproperty
  a_rxf_again: assert property (p_rxf_again) else $error("reload lost");

  property p_wake;
    @(posedge clk) disable iff (!reset_n)
    $rose(flag_q[`FLG_WAKE]) |-> $past(asleep && ctrl_q[`CTRL_WAKE_EN] && mask_q[`FLG_WAKE]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without conditions");

  property p_ovr;
    @(posedge clk) disable iff (!reset_n)
    rxOverrun |=> flag_q[`FLG_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_state;
    @(posedge clk) disable iff (!reset_n)
    tec_q >= `CNT_BUSOFF |=> txSt_q == can_rx_pkg::BUS_OFF && flagRd[5:4] == 2'h3;
  endproperty
  a_state: assert property (p_state) else $error("bus-off not reported");

  property p_irq;
    @(posedge clk) disable iff (!reset_n)
    |(flag_q & mask_q) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq dropped while flag set");

  property p_setwins;
    @(posedge clk) disable iff (!reset_n)
    rxOverrun && clrV[`FLG_OVR] |=> flag_q[`FLG_OVR];
  endproperty
  a_setwins: assert property (p_setwins) else $error("clear beat set");

  property p_txinc;
    @(posedge clk) disable iff (!reset_n)
    txErr && !busOffRecover && tec_q < 9'h0F8 |=> tec_q == $past(tec_q) + 9'h008;
  endproperty
  a_txinc: assert property (p_txinc) else $error("tx error step wrong");

  property p_rxe_read;
    @(posedge clk) disable iff (!reset_n)
    setup && isRxe && cntValid |=> prdata[7:0] == $past(rec_q);
  endproperty
  a_rxe_read: assert property (p_rxe_read) else $error("rx count read mismatch");

  property p_len_load;
    @(posedge clk) disable iff (!reset_n)
    rxFgLoad |=> len_q == $past(rxFgLength);
  endproperty
  a_len_load: assert property (p_len_load) else $error("length code not taken");

  property p_wake_set;
    @(posedge clk) disable iff (!reset_n)
    wakeEv |=> flag_q[`FLG_WAKE];
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake event lost");

  property p_stchg;
    @(posedge clk) disable iff (!reset_n)
    stChange |=> flag_q[`FLG_CSC];
  endproperty
  a_stchg: assert property (p_stchg) else $error("status change not flagged");

  property p_rx_warn;
    @(posedge clk) disable iff (!reset_n)
    rec_q >= 8'h60 && rec_q < 8'h80 |=> rxSt_q == can_rx_pkg::BUS_WARN && flagRd[3:2] == 2'h1;
  endproperty
  a_rx_warn: assert property (p_rx_warn) else $error("rx warning not reported");

  property p_release;
    @(posedge clk) disable iff (!reset_n)
    rxfCleared |=> rxRelease && !flag_q[`FLG_RXF];
  endproperty
  a_release: assert property (p_release) else $error("clear did not release");

  property p_rxdom;
    @(posedge clk) disable iff (!reset_n)
    rxErrDominant && !busOffRecover && rec_q < 8'hF8 |=> rec_q == $past(rec_q) + 8'h08;
  endproperty
  a_rxdom: assert property (p_rxdom) else $error("rx error step wrong");

  property p_busoff_hold;
    @(posedge clk) disable iff (!reset_n)
    txBusOff && !busOffRecover |=> tec_q == $past(tec_q);
  endproperty
  a_busoff_hold: assert property (p_busoff_hold) else $error("bus-off count moved");

  property p_txok;
    @(posedge clk) disable iff (!reset_n)
    txOk && !txErr && !busOffRecover && tec_q != 9'h000 && !txBusOff |=> tec_q == $past(tec_q) - 9'h001;
  endproperty
  a_txok: assert property (p_txok) else $error("tx success step wrong");

  c_rx: cover property (@(posedge clk) disable iff (!reset_n) rxFgLoad ##1 rxRelease);
  c_wake: cover property (@(posedge clk) disable iff (!reset_n) $rose(flag_q[`FLG_WAKE]));
  c_busoff: cover property (@(posedge clk) disable iff (!reset_n) txSt_q == can_rx_pkg::BUS_OFF);
  c_err: cover property (@(posedge clk) disable iff (!reset_n) setup && isTxe && cntValid);
endmodule

// ### pkg/can_rx_cfg.svh
// register map, field positions and reset values of the can receive status block
`ifndef CAN_RX_CFG_SVH
`define CAN_RX_CFG_SVH
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_FLAG 8'h08
`define OFF_MASK 8'h0C
`define OFF_TXERR 8'h10
`define OFF_RXERR 8'h14
`define OFF_LEN 8'h18
`define OFF_PAY 8'h20
`define OFF_PAY_END 8'h3C
`define CTRL_SLEEP 0
`define CTRL_INIT 1
`define CTRL_WAKE_EN 2
`define CTRL_PDOWN 3
`define FLG_RXF 0
`define FLG_OVR 1
`define FLG_RST_LO 2
`define FLG_TST_LO 4
`define FLG_CSC 6
`define FLG_WAKE 7
`define FLG_STICKY 8'hC3
`define RST_REG 8'h00
`define CNT_WARN 9'h060
`define CNT_PASSIVE 9'h080
`define CNT_BUSOFF 9'h100
`define CNT_TX_STEP 9'h008
`define CNT_RX_STEP 8'h08
`define PAY_BYTES 8
`endif

// ### pkg/can_rx_pkg.sv
// types shared by the can receive status block
package can_rx_pkg;
  // fault-confinement level of one error counter
  typedef enum logic [1:0] {
    BUS_OK,
    BUS_WARN,
    BUS_PASSIVE,
    BUS_OFF
  } bus_state_t;
endpackage

// ### tb/can_bus_node.sv
// behavioural far side: other bus nodes and protocol engine events
`timescale 1ns/10ps
module can_bus_node (
  // clock
  input wire logic clk,
  // receive fifo hand-over
  output logic rxFgLoad,
  output logic [63:0] rxFgData,
  output logic [3:0] rxFgLength,
  output logic rxOverrun,
  // fault-confinement events, txErr in bit 0
  output logic [5:0] ev,
  // bus pin, recessive high
  output logic canRx
);
  initial begin
    rxFgLoad = 1'b0;
    rxFgData = 64'h0;
    rxFgLength = 4'h0;
    rxOverrun = 1'b0;
    ev = 6'h00;
    canRx = 1'b1;
  end
  // a frame is handed over only at the end of frame
  task frame(input logic [63:0] d, input logic [3:0] n);
    rxFgLoad <= 1'b1;
    rxFgData <= d;
    rxFgLength <= n;
    @(posedge clk);
    rxFgLoad <= 1'b0;
    // stale data must not look valid once the strobe is gone
    rxFgData <= ~d;
    rxFgLength <= ~n;
  endtask
  // events stay up for n edges, so back-to-back events need no second assignment
  task pulse(input logic [6:0] e, input int n);
    ev <= e[5:0];
    rxOverrun <= e[6];
    repeat (n) @(posedge clk);
    ev <= 6'h00;
    rxOverrun <= 1'b0;
  endtask
  // dominant burst from another node
  task wake();
    canRx <= 1'b0;
    repeat (4) @(posedge clk);
    canRx <= 1'b1;
  endtask
endmodule

// ### tb/test_can_rx_status.sv
// self-checking bench for the can receive status block
`timescale 1ns/10ps
`include "can_rx_cfg.svh"
module test_can_rx_status;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, lfsr;
  logic pready, pslverr, er, rxRelease, irq, rxFgLoad, rxOverrun, canRx;
  logic [63:0] rxFgData;
  logic [3:0] rxFgLength;
  logic [5:0] ev;
  int err_total = 0;
  int checks_done = 0;
  int rel = 0;
  int clr = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (rxRelease === 1'b1) rel++;
  can_rx_status u_can_rx_status (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxFgLoad(rxFgLoad), .rxFgData(rxFgData), .rxFgLength(rxFgLength),
    .rxOverrun(rxOverrun), .rxRelease(rxRelease), .txErr(ev[0]), .txOk(ev[1]), .rxErr(ev[2]),
    .rxErrDominant(ev[3]), .rxOk(ev[4]), .busOffRecover(ev[5]), .canRx(canRx), .irq(irq));
  can_bus_node u_can_bus_node (.clk(clk), .rxFgLoad(rxFgLoad), .rxFgData(rxFgData),
    .rxFgLength(rxFgLength), .rxOverrun(rxOverrun), .ev(ev), .canRx(canRx));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // bytes past the length code read back as zero
  function automatic logic [31:0] pay_exp(input logic [63:0] d, input logic [3:0] n, input int k);
    return (k < n) ? {24'h0, d[8*k+:8]} : 32'h0;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // ld hands a frame over at the access edge of this transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ld = 1'b0);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    if (ld) fork u_can_bus_node.frame({lfsr, lfsr}, 4'h8); join_none
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rx_frame();
    logic [63:0] d;
    logic [3:0] n;
    lfsr = step(lfsr);
    d[31:0] = lfsr;
    lfsr = step(lfsr);
    d[63:32] = lfsr;
    n = lfsr[3:0];
    u_can_bus_node.frame(d, n);
    @(posedge clk);
    chk(irq, 1);
    apb(0, `OFF_FLAG, 0);
    chk(rd[0], 1);
    apb(0, `OFF_LEN, 0);
    chk(rd, {28'h0, n});
    for (int k = 0; k < `PAY_BYTES; k++) begin
      apb(0, 8'(`OFF_PAY + 4 * k), 0);
      chk(rd, pay_exp(d, n, k));
    end
    apb(1, `OFF_FLAG, 1);
    clr++;
    apb(0, `OFF_FLAG, 0);
    chk(rd[0], 0);
    chk(irq, 0);
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    lfsr = 32'h94C5;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    apb(0, `OFF_MASK, 0);
    chk(rd, 0);
    apb(1, `OFF_MASK, 32'h41);
    for (int i = 0; i < 4; i++) rx_frame();
    // frame arriving in the clearing cycle keeps the flag
    apb(1, `OFF_FLAG, 1, 1);
    apb(0, `OFF_FLAG, 0);
    chk(rd[0], 1);
    apb(0, `OFF_PAY, 0);
    chk(rd, {24'h0, lfsr[7:0]});
    apb(1, `OFF_FLAG, 1);
    clr++;
    apb(0, `OFF_FLAG, 0);
    chk(rd[0], 0);
    chk(rel, clr);
    chk(irq, 0);
    u_can_bus_node.pulse(7'h01, 12);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    apb(0, `OFF_FLAG, 0);
    chk(rd[6:4], 3'h5);
    apb(0, `OFF_TXERR, 0);
    chk(rd, 0);
    apb(1, `OFF_CTRL, 32'h02);
    apb(0, `OFF_STAT, 0);
    chk(rd[1], 1);
    apb(1, `OFF_TXERR, 32'h55);
    apb(0, `OFF_TXERR, 0);
    chk(rd, 32'h60);
    u_can_bus_node.pulse(7'h08, 12);
    apb(0, `OFF_RXERR, 0);
    chk(rd, 32'h60);
    apb(0, `OFF_FLAG, 0);
    chk(rd[6:2], 5'h15);
    u_can_bus_node.pulse(7'h02, 4);
    apb(0, `OFF_TXERR, 0);
    chk(rd, 32'h5C);
    u_can_bus_node.pulse(7'h01, 21);
    apb(0, `OFF_FLAG, 0);
    chk(rd[5:4], 2'h3);
    u_can_bus_node.pulse(7'h20, 1);
    apb(0, `OFF_TXERR, 0);
    chk(rd, 0);
    apb(1, `OFF_FLAG, 32'h41);
    apb(1, `OFF_MASK, 32'h82);
    u_can_bus_node.pulse(7'h40, 1);
    apb(0, `OFF_FLAG, 0);
    chk(rd[1], 1);
    chk(irq, 1);
    apb(1, `OFF_FLAG, 32'h02);
    apb(1, `OFF_CTRL, 32'h01);
    u_can_bus_node.wake();
    apb(0, `OFF_FLAG, 0);
    chk(rd[7], 0);
    apb(1, `OFF_CTRL, 32'h05);
    u_can_bus_node.wake();
    apb(0, `OFF_FLAG, 0);
    chk(rd[7], 1);
    chk(irq, 1);
    // power-down entered without acked sleep must not wake
    apb(1, `OFF_FLAG, 32'h80);
    apb(1, `OFF_CTRL, 32'h04);
    apb(1, `OFF_CTRL, 32'h0C);
    u_can_bus_node.wake();
    apb(0, `OFF_FLAG, 0);
    chk(rd[7], 0);
    apb(1, `OFF_CTRL, 32'h05);
    apb(1, `OFF_CTRL, 32'h0C);
    u_can_bus_node.wake();
    apb(0, `OFF_FLAG, 0);
    chk(rd[7], 1);
    apb(0, 8'h40, 0);
    chk(er, 1);
    chk(rd, 0);
    final_report();
  end
endmodule
